/* File: src/t16_pin_cond.sv */
// pin synchroniser, optional majority-free noise filter and edge detector
`timescale 1ns/100ps
`default_nettype none
`include "t16_regs.svh"
module t16_pin_cond #(
   parameter int FILTER_LEN = `T16_FILTER_LEN
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic pin,
   input wire logic filter_en,
   output logic rise,
   output logic fall
);
   logic sync1, sync2, level, level_d;
   logic [FILTER_LEN-1:0] hist;
   logic next_level;
   logic [FILTER_LEN-1:0] next_hist;

   always_comb
   begin
      next_hist = {hist[FILTER_LEN-2:0], sync2};
      next_level = sync2;
      if (filter_en)
      begin
         // level moves only once every sample in the window agrees
         if (&hist)
            next_level = 1'h1;
         else if (~|hist)
            next_level = 1'h0;
         else
            next_level = level;
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         sync1 <= 1'h0;
         sync2 <= 1'h0;
         hist <= '0;
         level <= 1'h0;
         level_d <= 1'h0;
      end
      else
      begin
         sync1 <= pin;
         sync2 <= sync1;
         hist <= next_hist;
         level <= next_level;
         level_d <= level;
      end
   end

   assign rise = level & ~level_d;
   assign fall = ~level & level_d;
endmodule
`default_nettype wire

/* File: src/t16_pkg.sv */
// types shared by the 16-bit timer files
package t16_pkg;
   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } t16_bus_req_t;
   typedef enum logic [1:0] {
      T16_CL_NORMAL = 2'b00,
      T16_CL_CTC = 2'b01,
      T16_CL_FAST = 2'b10,
      T16_CL_PHASE = 2'b11
   } t16_class_t;
   typedef enum logic {
      T16_UP = 1'b0,
      T16_DOWN = 1'b1
   } t16_dir_t;
endpackage

/* File: src/t16_regs.svh */
// register map, field positions and constants of the 16-bit timer
`ifndef T16_REGS_SVH
`define T16_REGS_SVH
`define T16_OFS_IRQ_FLAGS 6'h0B
`define T16_OFS_IRQ_MASK 6'h0C
`define T16_OFS_CTRL_C 6'h22
`define T16_OFS_CAPT_L 6'h24
`define T16_OFS_CAPT_H 6'h25
`define T16_OFS_MATCH_B_L 6'h28
`define T16_OFS_MATCH_B_H 6'h29
`define T16_OFS_MATCH_A_L 6'h2A
`define T16_OFS_MATCH_A_H 6'h2B
`define T16_OFS_COUNT_L 6'h2C
`define T16_OFS_COUNT_H 6'h2D
`define T16_OFS_CTRL_B 6'h2E
`define T16_OFS_CTRL_A 6'h2F
`define T16_B_FILT 7
`define T16_B_EDGE 6
`define T16_B_WM3 4
`define T16_B_WM2 3
`define T16_B_CS_HI 2
`define T16_A_COMA_HI 7
`define T16_A_COMA_LO 6
`define T16_A_COMB_HI 5
`define T16_A_COMB_LO 4
`define T16_A_WM1 1
`define T16_C_FORCE_A 7
`define T16_C_FORCE_B 6
`define T16_M_CAPT 5
`define T16_M_MB 2
`define T16_M_MA 1
`define T16_M_OV 0
`define T16_I_CAPT 3
`define T16_I_MB 2
`define T16_I_MA 1
`define T16_I_OV 0
`define T16_CS_STOP 3'h0
`define T16_CS_DIV1 3'h1
`define T16_CS_DIV8 3'h2
`define T16_CS_DIV64 3'h3
`define T16_CS_DIV256 3'h4
`define T16_CS_DIV1024 3'h5
`define T16_CS_EXT_FALL 3'h6
`define T16_CS_EXT_RISE 3'h7
`define T16_PS_TAP8 3
`define T16_PS_TAP64 6
`define T16_PS_TAP256 8
`define T16_PS_TAP1024 10
`define T16_COM_OFF 2'h0
`define T16_COM_TOGGLE 2'h1
`define T16_COM_CLEAR 2'h2
`define T16_COM_SET 2'h3
`define T16_MAX 16'hFFFF
`define T16_TOP8 16'h00FF
`define T16_TOP9 16'h01FF
`define T16_TOP10 16'h03FF
`define T16_BOTTOM 16'h0000
`define T16_ONE 16'h0001
`define T16_RST_BYTE 8'h00
`define T16_RST_WORD 16'h0000
`define T16_RST_NIB 4'h0
`define T16_FILTER_LEN 4
`endif

/* File: src/t16_timer.sv */
// 16-bit timer with two compare channels, input capture and byte register port
`timescale 1ns/100ps
`default_nettype none
`include "t16_regs.svh"
module t16_timer #(
   parameter int PRESC_W = `T16_PS_TAP1024
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire t16_pkg::t16_bus_req_t io_req,
   output logic [7:0] io_rdata,
   input wire logic global_irq_en,
   input wire logic [3:0] irq_ack,
   output logic [3:0] irq_req,
   input wire logic capture_in_pin,
   input wire logic comparator_out,
   input wire logic capture_src_cmp,
   input wire logic ext_count_pin,
   output logic wave_out_a,
   output logic wave_out_b
);
   import t16_pkg::*;

   logic [15:0] count_value, match_value_a, match_value_b, captured_count;
   logic [7:0] temp_hi, rdata;
   logic capture_filter_en, capture_edge_sel;
   logic [3:0] wave_mode;
   logic [2:0] clk_source_sel;
   logic [1:0] com_a, com_b;
   logic [3:0] irq_en, irq_flags, irq_out;
   t16_dir_t dir;
   logic block_match, wave_a, wave_b;
   logic [PRESC_W-1:0] presc;

   logic [15:0] next_count, next_match_a, next_match_b, next_capt;
   logic [7:0] next_temp, next_rdata;
   logic next_filt, next_edge;
   logic [3:0] next_wave_mode;
   logic [2:0] next_cs;
   logic [1:0] next_com_a, next_com_b;
   logic [3:0] next_irq_en, next_flags, next_irq_out, flag_set, flag_clr;
   t16_dir_t next_dir;
   logic next_block, next_wave_a, next_wave_b;
   logic [PRESC_W-1:0] next_presc;

   logic capt_rise, capt_fall, ext_rise, ext_fall;
   logic tick, hit_a, hit_b, force_a, force_b, at_bottom, capt_evt, icr_top, wr, rd;
   logic [15:0] top;
   t16_class_t cls;

   t16_pin_cond #(
      .FILTER_LEN(`T16_FILTER_LEN)
   ) u_capt_cond (
      .clock(clock),
      .sys_rst(sys_rst),
      .pin(capture_src_cmp ? comparator_out : capture_in_pin),
      .filter_en(capture_filter_en),
      .rise(capt_rise),
      .fall(capt_fall)
   );

   // pin is sampled regardless of its port direction
   t16_pin_cond #(
      .FILTER_LEN(`T16_FILTER_LEN)
   ) u_ext_cond (
      .clock(clock),
      .sys_rst(sys_rst),
      .pin(ext_count_pin),
      .filter_en(1'h0),
      .rise(ext_rise),
      .fall(ext_fall)
   );

   function automatic t16_class_t class_of(input logic [3:0] m);
      t16_class_t c;
      unique case (m)
         4'h0, 4'hD: c = T16_CL_NORMAL;
         4'h4, 4'hC: c = T16_CL_CTC;
         4'h5, 4'h6, 4'h7, 4'hE, 4'hF: c = T16_CL_FAST;
         default: c = T16_CL_PHASE;
      endcase
      return c;
   endfunction

   function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] ma,
                                          input logic [15:0] ic);
      logic [15:0] t;
      unique case (m)
         4'h1, 4'h5: t = `T16_TOP8;
         4'h2, 4'h6: t = `T16_TOP9;
         4'h3, 4'h7: t = `T16_TOP10;
         4'h4, 4'h9, 4'hB, 4'hF: t = ma;
         4'h8, 4'hA, 4'hC, 4'hE: t = ic;
         default: t = `T16_MAX;
      endcase
      return t;
   endfunction

   function automatic logic wave_next(input t16_class_t c, input logic [1:0] com,
                                      input logic cur, input logic hit, input logic bottom,
                                      input logic up, input logic tog_ok);
      logic r;
      r = cur;
      unique case (c)
         T16_CL_NORMAL, T16_CL_CTC:
         begin
            if (hit)
            begin
               unique case (com)
                  `T16_COM_TOGGLE: r = ~cur;
                  `T16_COM_CLEAR: r = 1'h0;
                  `T16_COM_SET: r = 1'h1;
                  `T16_COM_OFF: r = cur;
               endcase
            end
         end
         T16_CL_FAST:
         begin
            // bottom wins so a match at top is swallowed
            if (com == `T16_COM_CLEAR)
               r = bottom ? 1'h1 : (hit ? 1'h0 : cur);
            else if (com == `T16_COM_SET)
               r = bottom ? 1'h0 : (hit ? 1'h1 : cur);
            else if (com == `T16_COM_TOGGLE && tog_ok && hit)
               r = ~cur;
         end
         T16_CL_PHASE:
         begin
            if (hit && com == `T16_COM_CLEAR)
               r = ~up;
            else if (hit && com == `T16_COM_SET)
               r = up;
            else if (hit && com == `T16_COM_TOGGLE && tog_ok)
               r = ~cur;
         end
      endcase
      return r;
   endfunction

   function automatic logic [7:0] mask_byte(input logic [3:0] v);
      logic [7:0] b;
      b = `T16_RST_BYTE;
      b[`T16_M_CAPT] = v[`T16_I_CAPT];
      b[`T16_M_MB] = v[`T16_I_MB];
      b[`T16_M_MA] = v[`T16_I_MA];
      b[`T16_M_OV] = v[`T16_I_OV];
      return b;
   endfunction

   always_comb
   begin
      wr = io_req.wr;
      rd = io_req.rd & ~io_req.wr;
      cls = class_of(wave_mode);
      top = top_of(wave_mode, match_value_a, captured_count);
      icr_top = (top_of(wave_mode, `T16_RST_WORD, `T16_MAX) == `T16_MAX) &&
                (top_of(wave_mode, `T16_MAX, `T16_RST_WORD) == `T16_RST_WORD);
      next_presc = presc + {{(PRESC_W-1){1'b0}}, 1'b1};
      unique case (clk_source_sel)
         `T16_CS_STOP: tick = 1'h0;
         `T16_CS_DIV1: tick = 1'h1;
         `T16_CS_DIV8: tick = &presc[`T16_PS_TAP8-1:0];
         `T16_CS_DIV64: tick = &presc[`T16_PS_TAP64-1:0];
         `T16_CS_DIV256: tick = &presc[`T16_PS_TAP256-1:0];
         `T16_CS_DIV1024: tick = &presc[`T16_PS_TAP1024-1:0];
         `T16_CS_EXT_FALL: tick = ext_fall;
         `T16_CS_EXT_RISE: tick = ext_rise;
      endcase

      next_count = count_value;
      next_dir = dir;
      next_block = block_match;
      flag_set = `T16_RST_NIB;
      at_bottom = 1'h0;
      hit_a = 1'h0;
      hit_b = 1'h0;
      if (tick)
      begin
         next_block = 1'h0;
         hit_a = ~block_match && (count_value == match_value_a);
         hit_b = ~block_match && (count_value == match_value_b);
         flag_set[`T16_I_MA] = hit_a;
         flag_set[`T16_I_MB] = hit_b;
         if (icr_top && count_value == top)
            flag_set[`T16_I_CAPT] = 1'h1;
         if (cls == T16_CL_PHASE)
         begin
            if (dir == T16_UP && count_value >= top)
            begin
               next_dir = T16_DOWN;
               next_count = count_value - `T16_ONE;
            end
            else if (dir == T16_DOWN && count_value == `T16_BOTTOM)
            begin
               next_dir = T16_UP;
               next_count = count_value + `T16_ONE;
               flag_set[`T16_I_OV] = 1'h1;
            end
            else if (dir == T16_UP)
               next_count = count_value + `T16_ONE;
            else
               next_count = count_value - `T16_ONE;
         end
         else
         begin
            next_dir = T16_UP;
            if (count_value == top)
            begin
               next_count = `T16_BOTTOM;
               at_bottom = 1'h1;
            end
            else
               next_count = count_value + `T16_ONE;
            if (cls == T16_CL_FAST)
               flag_set[`T16_I_OV] = (count_value == top);
            else
               flag_set[`T16_I_OV] = (count_value == `T16_MAX);
         end
      end

      // capture pin is dropped while the capture register sets the period
      capt_evt = ~icr_top && (capture_edge_sel ? capt_rise : capt_fall);
      next_capt = captured_count;
      if (capt_evt)
      begin
         next_capt = count_value;
         flag_set[`T16_I_CAPT] = 1'h1;
      end

      force_a = 1'h0;
      force_b = 1'h0;
      next_temp = temp_hi;
      next_match_a = match_value_a;
      next_match_b = match_value_b;
      next_filt = capture_filter_en;
      next_edge = capture_edge_sel;
      next_wave_mode = wave_mode;
      next_cs = clk_source_sel;
      next_com_a = com_a;
      next_com_b = com_b;
      next_irq_en = irq_en;
      flag_clr = irq_ack;
      if (wr)
      begin
         unique case (io_req.addr)
            `T16_OFS_CTRL_B:
            begin
               next_filt = io_req.wdata[`T16_B_FILT];
               next_edge = io_req.wdata[`T16_B_EDGE];
               next_wave_mode[3:2] = io_req.wdata[`T16_B_WM3:`T16_B_WM2];
               next_cs = io_req.wdata[`T16_B_CS_HI:0];
            end
            `T16_OFS_CTRL_A:
            begin
               next_com_a = io_req.wdata[`T16_A_COMA_HI:`T16_A_COMA_LO];
               next_com_b = io_req.wdata[`T16_A_COMB_HI:`T16_A_COMB_LO];
               next_wave_mode[1:0] = io_req.wdata[`T16_A_WM1:0];
            end
            `T16_OFS_CTRL_C:
            begin
               force_a = io_req.wdata[`T16_C_FORCE_A] && cls[1] == 1'b0;
               force_b = io_req.wdata[`T16_C_FORCE_B] && cls[1] == 1'b0;
            end
            `T16_OFS_IRQ_MASK:
            begin
               next_irq_en[`T16_I_CAPT] = io_req.wdata[`T16_M_CAPT];
               next_irq_en[`T16_I_MB] = io_req.wdata[`T16_M_MB];
               next_irq_en[`T16_I_MA] = io_req.wdata[`T16_M_MA];
               next_irq_en[`T16_I_OV] = io_req.wdata[`T16_M_OV];
            end
            `T16_OFS_IRQ_FLAGS:
            begin
               flag_clr[`T16_I_CAPT] = irq_ack[`T16_I_CAPT] | io_req.wdata[`T16_M_CAPT];
               flag_clr[`T16_I_MB] = irq_ack[`T16_I_MB] | io_req.wdata[`T16_M_MB];
               flag_clr[`T16_I_MA] = irq_ack[`T16_I_MA] | io_req.wdata[`T16_M_MA];
               flag_clr[`T16_I_OV] = irq_ack[`T16_I_OV] | io_req.wdata[`T16_M_OV];
            end
            `T16_OFS_COUNT_H, `T16_OFS_MATCH_A_H, `T16_OFS_MATCH_B_H, `T16_OFS_CAPT_H:
               next_temp = io_req.wdata;
            `T16_OFS_COUNT_L:
            begin
               next_count = {temp_hi, io_req.wdata};
               next_block = 1'h1;
            end
            `T16_OFS_MATCH_A_L: next_match_a = {temp_hi, io_req.wdata};
            `T16_OFS_MATCH_B_L: next_match_b = {temp_hi, io_req.wdata};
            `T16_OFS_CAPT_L: next_capt = {temp_hi, io_req.wdata};
            default: next_temp = temp_hi;
         endcase
      end

      next_rdata = `T16_RST_BYTE;
      if (rd)
      begin
         unique case (io_req.addr)
            `T16_OFS_CTRL_B:
            begin
               next_rdata[`T16_B_FILT] = capture_filter_en;
               next_rdata[`T16_B_EDGE] = capture_edge_sel;
               next_rdata[`T16_B_WM3:`T16_B_WM2] = wave_mode[3:2];
               next_rdata[`T16_B_CS_HI:0] = clk_source_sel;
            end
            `T16_OFS_CTRL_A:
            begin
               next_rdata[`T16_A_COMA_HI:`T16_A_COMA_LO] = com_a;
               next_rdata[`T16_A_COMB_HI:`T16_A_COMB_LO] = com_b;
               next_rdata[`T16_A_WM1:0] = wave_mode[1:0];
            end
            `T16_OFS_CTRL_C: next_rdata = `T16_RST_BYTE;
            `T16_OFS_IRQ_MASK: next_rdata = mask_byte(irq_en);
            `T16_OFS_IRQ_FLAGS: next_rdata = mask_byte(irq_flags);
            `T16_OFS_COUNT_L:
            begin
               next_rdata = count_value[7:0];
               next_temp = count_value[15:8];
            end
            `T16_OFS_CAPT_L:
            begin
               next_rdata = captured_count[7:0];
               next_temp = captured_count[15:8];
            end
            `T16_OFS_COUNT_H, `T16_OFS_CAPT_H: next_rdata = temp_hi;
            `T16_OFS_MATCH_A_L: next_rdata = match_value_a[7:0];
            `T16_OFS_MATCH_A_H: next_rdata = match_value_a[15:8];
            `T16_OFS_MATCH_B_L: next_rdata = match_value_b[7:0];
            `T16_OFS_MATCH_B_H: next_rdata = match_value_b[15:8];
            default: next_rdata = `T16_RST_BYTE;
         endcase
      end

      // a new event outranks a clear landing in the same cycle
      next_flags = flag_set | (irq_flags & ~flag_clr);
      next_irq_out = irq_flags & irq_en & {4{global_irq_en}};
      // forced strobes drive the output only: no flag, no counter clear
      next_wave_a = wave_next(cls, com_a, wave_a, hit_a | force_a, at_bottom,
                              dir == T16_UP, wave_mode[3]);
      next_wave_b = wave_next(cls, com_b, wave_b, hit_b | force_b, at_bottom,
                              dir == T16_UP, 1'h0);
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         count_value <= `T16_RST_WORD;
         match_value_a <= `T16_RST_WORD;
         match_value_b <= `T16_RST_WORD;
         captured_count <= `T16_RST_WORD;
         temp_hi <= `T16_RST_BYTE;
         rdata <= `T16_RST_BYTE;
         capture_filter_en <= 1'h0;
         capture_edge_sel <= 1'h0;
         wave_mode <= `T16_RST_NIB;
         clk_source_sel <= `T16_CS_STOP;
         com_a <= `T16_COM_OFF;
         com_b <= `T16_COM_OFF;
         irq_en <= `T16_RST_NIB;
         irq_flags <= `T16_RST_NIB;
         irq_out <= `T16_RST_NIB;
         dir <= T16_UP;
         block_match <= 1'h0;
         wave_a <= 1'h0;
         wave_b <= 1'h0;
         presc <= '0;
      end
      else
      begin
         count_value <= next_count;
         match_value_a <= next_match_a;
         match_value_b <= next_match_b;
         captured_count <= next_capt;
         temp_hi <= next_temp;
         rdata <= next_rdata;
         capture_filter_en <= next_filt;
         capture_edge_sel <= next_edge;
         wave_mode <= next_wave_mode;
         clk_source_sel <= next_cs;
         com_a <= next_com_a;
         com_b <= next_com_b;
         irq_en <= next_irq_en;
         irq_flags <= next_flags;
         irq_out <= next_irq_out;
         dir <= next_dir;
         block_match <= next_block;
         wave_a <= next_wave_a;
         wave_b <= next_wave_b;
         presc <= next_presc;
      end
   end

   assign io_rdata = rdata;
   assign irq_req = irq_out;
   assign wave_out_a = wave_a;
   assign wave_out_b = wave_b;
endmodule
`default_nettype wire

/* File: tb/t16_cpu_model.sv */
// core model: byte register bus, global interrupt flag, vector acks
`timescale 1ns/100ps
`default_nettype none
module t16_cpu_model (
   input wire logic clock,
   input wire logic [7:0] io_rdata,
   output var t16_pkg::t16_bus_req_t io_req,
   output var logic global_irq_en,
   output var logic [3:0] irq_ack
);
   import t16_pkg::*;
   int gap = 0;
   initial
   begin
      io_req = '0;
      global_irq_en = 1'b0;
      irq_ack = 4'h0;
   end
   // raw skips the reserved-bit masking, only for refusal checks
   task automatic wr(input logic [5:0] a, input logic [7:0] x, input bit raw = 1'b0);
      logic [7:0] y;
      y = x;
      if (!raw && a == 6'h2E)
         y[5] = 1'b0;
      if (!raw && a == 6'h0C)
         y = y & 8'h27;
      if (!raw && a == 6'h22)
         y = y & 8'hC0;
      repeat (gap) @(posedge clock);
      @(posedge clock);
      io_req <= '{a, y, 1'b1, 1'b0};
      @(posedge clock);
      io_req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] x);
      repeat (gap) @(posedge clock);
      @(posedge clock);
      io_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clock);
      io_req.rd <= 1'b0;
      #1 x = io_rdata;
   endtask
   task automatic ack(input logic [3:0] m);
      @(posedge clock);
      irq_ack <= m;
      @(posedge clock);
      irq_ack <= 4'h0;
   endtask
endmodule
`default_nettype wire

/* File: tb/t16_timer_props.sv */
// port assertions and covers for the 16-bit timer
`timescale 1ns/100ps
`default_nettype none
module t16_timer_props #(
   parameter int PRESC_W = 10
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire t16_pkg::t16_bus_req_t io_req,
   input wire logic [7:0] io_rdata,
   input wire logic global_irq_en,
   input wire logic [3:0] irq_ack,
   input wire logic [3:0] irq_req,
   input wire logic capture_in_pin,
   input wire logic comparator_out,
   input wire logic capture_src_cmp,
   input wire logic ext_count_pin,
   input wire logic wave_out_a,
   input wire logic wave_out_b
);
   import t16_pkg::*;
   default clocking @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   logic rd_ok;
   logic [7:0] mask_seen;
   assign rd_ok = io_req.rd && !io_req.wr;
   // shadow of the mask so a read can be tied to the last write
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         mask_seen <= 8'h00;
      else if (io_req.wr && io_req.addr == 6'h0C)
         mask_seen <= io_req.wdata & 8'h27;
   end
   a_rdata_idle: assert property (!rd_ok |=> io_rdata == 8'h00)
      else $error("read data not zero while idle");
   a_mask_value: assert property (rd_ok && io_req.addr == 6'h0C |=> io_rdata == mask_seen)
      else $error("mask read differs from written enables");
   a_flags_rsv: assert property (rd_ok && io_req.addr == 6'h0B |=> (io_rdata & 8'hD8) == 8'h00)
      else $error("flag reserved bits not zero");
   a_ctrlb_rsv: assert property (rd_ok && io_req.addr == 6'h2E |=> !io_rdata[5])
      else $error("control b bit 5 not zero");
   a_force_zero: assert property (rd_ok && io_req.addr == 6'h22 |=> io_rdata == 8'h00)
      else $error("force strobes read back nonzero");
   a_unmapped_zero: assert property (rd_ok && io_req.addr == 6'h00 |=> io_rdata == 8'h00)
      else $error("unmapped read nonzero");
   a_irq_global: assert property (!global_irq_en |=> irq_req == 4'h0)
      else $error("request without global enable");
   a_reset_quiet: assert property ($fell(sys_rst) |-> irq_req == 4'h0 && !wave_out_a && !wave_out_b)
      else $error("outputs active after reset");
   cover property (rd_ok && io_req.addr == 6'h2D);
   cover property (irq_req != 4'h0);
   cover property ($rose(wave_out_a));
endmodule
bind t16_timer t16_timer_props #(.PRESC_W(PRESC_W)) chk (.clock(clock), .sys_rst(sys_rst),
   .io_req(io_req), .io_rdata(io_rdata), .global_irq_en(global_irq_en), .irq_ack(irq_ack),
   .irq_req(irq_req), .capture_in_pin(capture_in_pin), .comparator_out(comparator_out),
   .capture_src_cmp(capture_src_cmp), .ext_count_pin(ext_count_pin),
   .wave_out_a(wave_out_a), .wave_out_b(wave_out_b));
`default_nettype wire

/* File: tb/t16_timer_test.sv */
// self-checking bench for the 16-bit timer
`timescale 1ns/100ps
`default_nettype none
module t16_timer_test;
   import t16_pkg::*;
   logic clock, sys_rst, capture_in_pin, comparator_out, capture_src_cmp, ext_count_pin;
   logic wave_out_a, wave_out_b, global_irq_en;
   logic [7:0] io_rdata, d;
   logic [3:0] irq_ack, irq_req;
   logic [15:0] v, w;
   logic [6:0] c;
   t16_bus_req_t io_req;
   int errors = 0;
   int compares = 0;
   int k, cnt;
   logic [15:0] capq[$];
   int dv[6] = '{1, 1, 8, 64, 256, 1024};
   logic [5:0] zero_a[6] = '{6'h0C, 6'h2E, 6'h0B, 6'h2D, 6'h22, 6'h00};
   logic [5:0] rs_a[3] = '{6'h0C, 6'h2E, 6'h22};
   logic [7:0] rs_e[3] = '{8'h27, 8'hDF, 8'h00};
   logic [1:0] com_t[4] = '{2'h3, 2'h2, 2'h1, 2'h1};
   // bits: wave mode 12, filter, edge, comparator source, glitch, new level, capture expected
   logic [6:0] cap_t[8] = '{7'h13, 7'h10, 7'h02, 7'h01, 7'h1B, 7'h2C, 7'h29, 7'h52};
   t16_timer dut (.clock(clock), .sys_rst(sys_rst), .io_req(io_req), .io_rdata(io_rdata),
      .global_irq_en(global_irq_en), .irq_ack(irq_ack), .irq_req(irq_req),
      .capture_in_pin(capture_in_pin), .comparator_out(comparator_out),
      .capture_src_cmp(capture_src_cmp), .ext_count_pin(ext_count_pin),
      .wave_out_a(wave_out_a), .wave_out_b(wave_out_b));
   t16_cpu_model cpu (.clock(clock), .io_rdata(io_rdata), .io_req(io_req),
      .global_irq_en(global_irq_en), .irq_ack(irq_ack));
   task automatic stop_test;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e)
      begin
         errors++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   // prescaler phase is free running, so one tick either way is allowed
   task automatic chk_near(input string n, input int e, input logic [15:0] g);
      compares++;
      if ($isunknown(g) || g > e + 1 || g + 1 < e)
      begin
         errors++;
         $display("BAD %s exp %0d got %h", n, e, g);
      end
   endtask
   task automatic wr16(input logic [5:0] a, input logic [15:0] x);
      cpu.wr(a + 6'h01, x[15:8]);
      cpu.wr(a, x[7:0]);
   endtask
   task automatic rd16(input logic [5:0] a, output logic [15:0] x);
      cpu.rd(a, x[7:0]);
      cpu.rd(a + 6'h01, x[15:8]);
   endtask
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial
   begin
      repeat (60000) @(posedge clock);
      errors++;
      $display("BAD watchdog exp done got hang");
      stop_test;
   end
   initial
   begin
      sys_rst = 1'b1;
      capture_in_pin = 1'b0;
      comparator_out = 1'b0;
      capture_src_cmp = 1'b0;
      ext_count_pin = 1'b0;
      void'($urandom(32'h40d767c2));
      repeat (8) @(posedge clock);
      sys_rst <= 1'b0;
      foreach (zero_a[i])
      begin
         cpu.rd(zero_a[i], d);
         chk("reset", 16'h0000, 16'(d));
      end
      foreach (rs_a[i])
      begin
         cpu.wr(rs_a[i], 8'hFF & ~{2'h0, rs_a[i] == 6'h22, 5'h0}, 1'b1);
         cpu.rd(rs_a[i], d);
         chk("reserved", 16'(rs_e[i]), 16'(d));
      end
      cpu.wr(6'h2E, 8'h00);
      cpu.gap = $urandom_range(2, 0);
      v = 16'($urandom);
      wr16(6'h2C, v);
      rd16(6'h2C, w);
      chk("count", v, w);
      cpu.wr(6'h2D, 8'hAB);
      cpu.wr(6'h2A, 8'h11);
      rd16(6'h2A, w);
      chk("shared_latch", 16'hAB11, w);
      cpu.gap = 0;
      for (k = 0; k < 6; k++)
      begin
         wr16(6'h2C, 16'h0000);
         cpu.wr(6'h2E, 8'(k));
         repeat (2048) @(posedge clock);
         cpu.wr(6'h2E, 8'h00);
         rd16(6'h2C, w);
         chk_near("prescale", (k == 0) ? 0 : 2050 / dv[k], w);
      end
      for (k = 6; k < 8; k++)
      begin
         wr16(6'h2C, 16'h0000);
         cpu.wr(6'h2E, 8'(k));
         cnt = $urandom_range(9, 3);
         repeat (cnt)
         begin
            ext_count_pin <= 1'b1;
            repeat (4) @(posedge clock);
            ext_count_pin <= 1'b0;
            repeat (4) @(posedge clock);
         end
         ext_count_pin <= 1'b1;
         repeat (8) @(posedge clock);
         cpu.wr(6'h2E, 8'h00);
         ext_count_pin <= 1'b0;
         rd16(6'h2C, w);
         chk("ext_count", 16'(cnt + k - 6), w);
      end
      wr16(6'h2A, 16'h0040);
      wr16(6'h28, 16'h0048);
      wr16(6'h2C, 16'h0030);
      cpu.wr(6'h0C, 8'h06);
      cpu.global_irq_en <= 1'b1;
      cpu.wr(6'h2E, 8'h01);
      repeat (40) @(posedge clock);
      cpu.wr(6'h2E, 8'h00);
      cpu.rd(6'h0B, d);
      chk("flags", 16'h0006, 16'(d));
      #1 chk("irq", 16'h0006, 16'(irq_req));
      cpu.global_irq_en <= 1'b0;
      repeat (2) @(posedge clock);
      #1 chk("irq_off", 16'h0000, 16'(irq_req));
      cpu.global_irq_en <= 1'b1;
      cpu.ack(4'b0010);
      cpu.rd(6'h0B, d);
      chk("ack", 16'h0004, 16'(d));
      cpu.wr(6'h0B, 8'h04);
      cpu.rd(6'h0B, d);
      chk("w1c", 16'h0000, 16'(d));
      wr16(6'h2A, 16'h0100);
      cpu.wr(6'h2E, 8'h01);
      wr16(6'h2C, 16'h0100);
      repeat (8) @(posedge clock);
      cpu.wr(6'h2E, 8'h00);
      cpu.rd(6'h0B, d);
      chk("blocked", 16'h0000, 16'(d));
      wr16(6'h2C, 16'hFFF0);
      cpu.wr(6'h2E, 8'h01);
      repeat (24) @(posedge clock);
      cpu.wr(6'h2E, 8'h00);
      cpu.rd(6'h0B, d);
      chk("overflow", 16'h0001, 16'(d));
      cpu.wr(6'h0B, 8'h01);
      cpu.wr(6'h2E, 8'h08);
      rd16(6'h2C, v);
      for (k = 0; k < 4; k++)
      begin
         cpu.wr(6'h2F, {com_t[k], com_t[k], 4'h0});
         cpu.wr(6'h22, 8'hC0);
         repeat (2) @(posedge clock);
         #1 chk("wave", 16'({2{~k[0]}}), 16'({wave_out_a, wave_out_b}));
      end
      rd16(6'h2C, w);
      chk("force_count", v, w);
      cpu.rd(6'h0B, d);
      chk("force_flags", 16'h0000, 16'(d));
      foreach (cap_t[i])
      begin
         c = cap_t[i];
         v = 16'($urandom);
         wr16(6'h2C, v);
         cpu.wr(6'h2E, {c[5], c[4], 1'b0, c[6], c[6], 3'h0});
         capture_src_cmp <= c[3];
         repeat (8) @(posedge clock);
         cpu.wr(6'h0B, 8'h20);
         if (c[3])
            comparator_out <= c[1];
         else
            capture_in_pin <= c[1];
         repeat (2) @(posedge clock);
         if (c[2])
            comparator_out <= ~c[1];
         repeat (16) @(posedge clock);
         if (c[0])
            capq.push_back(v);
         cpu.rd(6'h0B, d);
         chk("capture_flag", 16'(c[0]), 16'(d[5]));
         if (c[0])
         begin
            rd16(6'h24, w);
            chk("captured", capq.pop_front(), w);
         end
      end
      stop_test;
   end
endmodule
`default_nettype wire
